// >>> tcm_pkg.sv
`default_nettype none
package tcm_pkg;
	// Channel count and which channels carry the extra C/D general registers.
	localparam int CH_NUM = 6;
	localparam logic [5:0] CD_MASK = 6'h09;

	// Register bus layout.
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] MODE_BASE_OFS = 5'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h18;
	localparam int WORD_SHIFT = 2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Mode register fields.
	localparam int MODE_W = 8;
	localparam int RSV_HI_POS = 7;
	localparam int RSV_LO_POS = 6;
	localparam int BUF_B_POS = 5;
	localparam int BUF_A_POS = 4;
	localparam int MD_HI_POS = 3;
	localparam int MD_BIT2_POS = 2;
	localparam logic [1:0] RSV_READ_VAL = 2'h3;
	localparam logic [7:0] MODE_RESET_VAL = 8'hC0;
	localparam logic [3:0] MD_RESET_VAL = 4'h0;

	// Mode field codes.
	localparam logic [3:0] MD_NORMAL = 4'h0;
	localparam logic [3:0] MD_RESERVED = 4'h1;
	localparam logic [3:0] MD_PWM1 = 4'h2;
	localparam logic [3:0] MD_PWM2 = 4'h3;
	localparam logic [1:0] MD_PHASE_TOP = 2'h1;

	// Status word fields.
	localparam int STAT_UNDEF_POS = 0;
	localparam int STAT_PHASE_POS = 8;

	typedef enum logic {TCM_BUS_IDLE, TCM_BUS_ACK} tcm_bus_t;

	// True when a mode code names a real mode on a channel of the given kind.
	function automatic logic tcm_mode_defined(input logic [3:0] code, input logic has_cd);
		tcm_mode_defined = !code[MD_HI_POS] && (code != MD_RESERVED) &&
			!(has_cd && code[MD_BIT2_POS]);
	endfunction
endpackage
`default_nettype wire

// >>> tcm_mode_slot.sv
`timescale 1ns/1ns
`default_nettype none
module tcm_mode_slot #(
	parameter bit HAS_CD = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [tcm_pkg::MODE_W-1:0] wr_data,
	output logic [tcm_pkg::MODE_W-1:0] reg_val,
	output logic buf_a,
	output logic buf_b,
	output logic [3:0] md_code,
	output logic defined
);
	import tcm_pkg::*;

	logic bf_b_r;
	logic bf_a_r;
	logic [3:0] md_r;
	logic bf_b_nxt;
	logic bf_a_nxt;

	// Channels without C/D keep the buffer bits at zero whatever is written.
	assign bf_b_nxt = HAS_CD ? wr_data[BUF_B_POS] : 1'b0;
	assign bf_a_nxt = HAS_CD ? wr_data[BUF_A_POS] : 1'b0;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bf_b_r <= 1'b0;
			bf_a_r <= 1'b0;
			md_r <= MD_RESET_VAL;
		end else if (wr_en) begin
			bf_b_r <= bf_b_nxt;
			bf_a_r <= bf_a_nxt;
			md_r <= wr_data[MD_HI_POS:0];
		end
	end

	// The top two bits are not stored: they always read back as ones.
	assign reg_val = {RSV_READ_VAL, bf_b_r, bf_a_r, md_r};
	assign buf_a = bf_a_r;
	assign buf_b = bf_b_r;
	assign md_code = md_r;
	assign defined = tcm_mode_defined(md_r, HAS_CD);
endmodule
`default_nettype wire

// >>> tcm_mode_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tcm_mode_regs #(
	parameter int CH_COUNT = tcm_pkg::CH_NUM
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [tcm_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [tcm_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [tcm_pkg::DATA_W-1:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest,
	input wire logic [tcm_pkg::CH_NUM-1:0] evt_c_raw,
	input wire logic [tcm_pkg::CH_NUM-1:0] evt_d_raw,
	output logic [tcm_pkg::CH_NUM-1:0] evt_c_out,
	output logic [tcm_pkg::CH_NUM-1:0] evt_d_out,
	output logic [tcm_pkg::CH_NUM-1:0] buf_a_en,
	output logic [tcm_pkg::CH_NUM-1:0] buf_b_en,
	output logic [tcm_pkg::CH_NUM-1:0] mode_normal,
	output logic [tcm_pkg::CH_NUM-1:0] mode_pwm1,
	output logic [tcm_pkg::CH_NUM-1:0] mode_pwm2,
	output logic [tcm_pkg::CH_NUM-1:0] mode_phase,
	output logic [2*tcm_pkg::CH_NUM-1:0] phase_sel,
	output logic [tcm_pkg::CH_NUM-1:0] mode_undef
);
	import tcm_pkg::*;

	if (CH_COUNT != CH_NUM) begin : g_bad_count
		$error("tcm_mode_regs: CH_COUNT must equal the six channels of the unit");
	end

	tcm_bus_t st_r;
	tcm_bus_t st_nxt;
	logic wait_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0] resp_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [1:0] resp_nxt;

	logic [MODE_W-1:0] slot_val [CH_NUM];
	logic [CH_NUM-1:0] slot_buf_a;
	logic [CH_NUM-1:0] slot_buf_b;
	logic [3:0] slot_md [CH_NUM];
	logic [CH_NUM-1:0] slot_def;
	logic [CH_NUM-1:0] slot_wr;
	logic [CH_NUM-1:0] phase_now;

	logic req;
	logic commit;
	logic aligned;
	logic [ADDR_W-WORD_SHIFT-1:0] word_idx;
	logic hit_mode;
	logic hit_status;
	logic hit_any;
	logic [MODE_W-1:0] mode_rd;
	logic [DATA_W-1:0] status_word;

	logic [CH_NUM-1:0] evt_c_r;
	logic [CH_NUM-1:0] evt_d_r;
	logic [CH_NUM-1:0] buf_a_r;
	logic [CH_NUM-1:0] buf_b_r;
	logic [CH_NUM-1:0] normal_r;
	logic [CH_NUM-1:0] pwm1_r;
	logic [CH_NUM-1:0] pwm2_r;
	logic [CH_NUM-1:0] phase_r;
	logic [2*CH_NUM-1:0] phase_sel_r;
	logic [CH_NUM-1:0] undef_r;

	// Address decode. Each channel's mode register is one aligned word.
	assign req = avs_read || avs_write;
	assign aligned = (avs_address[WORD_SHIFT-1:0] == 2'h0);
	assign word_idx = avs_address[ADDR_W-1:WORD_SHIFT];
	assign hit_mode = aligned && (avs_address >= MODE_BASE_OFS) &&
		(word_idx < 3'(CH_NUM));
	assign hit_status = (avs_address == STATUS_OFS);
	assign hit_any = hit_mode || hit_status;
	// A write lands only on the edge where waitrequest is seen low.
	assign commit = avs_write && (st_r == TCM_BUS_ACK);
	assign mode_rd = hit_mode ? slot_val[word_idx] : MODE_RESET_VAL;

	// Status shows which channels hold an undefined code and which count phases.
	always_comb begin
		status_word = '0;
		status_word[STAT_UNDEF_POS +: CH_NUM] = ~slot_def;
		status_word[STAT_PHASE_POS +: CH_NUM] = phase_now;
	end

	always_comb begin
		rdata_nxt = '0;
		if (avs_read && hit_mode) begin
			rdata_nxt[MODE_W-1:0] = mode_rd;
		end else if (avs_read && hit_status) begin
			rdata_nxt = status_word;
		end
	end

	assign resp_nxt = hit_any ? RESP_OK : RESP_SLVERR;

	// Fixed one wait state keeps the read path a single registered mux.
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			TCM_BUS_IDLE: begin
				if (req) begin
					st_nxt = TCM_BUS_ACK;
				end
			end
			TCM_BUS_ACK: begin
				st_nxt = TCM_BUS_IDLE;
			end
			default: begin
				st_nxt = TCM_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r <= TCM_BUS_IDLE;
			wait_r <= 1'b1;
			rdata_r <= '0;
			resp_r <= RESP_OK;
		end else begin
			st_r <= st_nxt;
			wait_r <= (st_nxt != TCM_BUS_ACK);
			if (st_r == TCM_BUS_IDLE && req) begin
				rdata_r <= rdata_nxt;
				resp_r <= resp_nxt;
			end
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_response = resp_r;
	assign avs_waitrequest = wait_r;

	genvar g;
	for (g = 0; g < CH_NUM; g++) begin : g_ch
		assign slot_wr[g] = commit && hit_mode && avs_byteenable[0] &&
			(word_idx == 3'(g));

		tcm_mode_slot #(
			.HAS_CD(CD_MASK[g])
		) u_slot (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.wr_en(slot_wr[g]),
			.wr_data(avs_writedata[MODE_W-1:0]),
			.reg_val(slot_val[g]),
			.buf_a(slot_buf_a[g]),
			.buf_b(slot_buf_b[g]),
			.md_code(slot_md[g]),
			.defined(slot_def[g])
		);

		assign phase_now[g] = slot_def[g] &&
			(slot_md[g][MD_HI_POS:MD_BIT2_POS+1] == 1'b0) &&
			(slot_md[g][MD_HI_POS-1:MD_BIT2_POS] == 1'b1);

		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				normal_r[g] <= 1'b1;
				pwm1_r[g] <= 1'b0;
				pwm2_r[g] <= 1'b0;
				phase_r[g] <= 1'b0;
				phase_sel_r[2*g +: 2] <= 2'h0;
				undef_r[g] <= 1'b0;
			end else begin
				normal_r[g] <= (slot_md[g] == MD_NORMAL);
				pwm1_r[g] <= (slot_md[g] == MD_PWM1);
				pwm2_r[g] <= (slot_md[g] == MD_PWM2);
				phase_r[g] <= phase_now[g];
				phase_sel_r[2*g +: 2] <= slot_md[g][1:0];
				undef_r[g] <= !slot_def[g];
			end
		end
	end

	// Buffer enables and event gating share one register stage so they stay aligned.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			buf_a_r <= '0;
			buf_b_r <= '0;
			evt_c_r <= '0;
			evt_d_r <= '0;
		end else begin
			buf_a_r <= slot_buf_a;
			buf_b_r <= slot_buf_b;
			evt_c_r <= evt_c_raw & ~slot_buf_a;
			evt_d_r <= evt_d_raw & ~slot_buf_b;
		end
	end

	assign buf_a_en = buf_a_r;
	assign buf_b_en = buf_b_r;
	assign evt_c_out = evt_c_r;
	assign evt_d_out = evt_d_r;
	assign mode_normal = normal_r;
	assign mode_pwm1 = pwm1_r;
	assign mode_pwm2 = pwm2_r;
	assign mode_phase = phase_r;
	assign phase_sel = phase_sel_r;
	assign mode_undef = undef_r;

	logic ch0_wr;
	logic ch1_wr;
	assign ch0_wr = commit && hit_mode && avs_byteenable[0] && (word_idx == 3'h0);
	assign ch1_wr = commit && hit_mode && avs_byteenable[0] && (word_idx == 3'h1);

	chk_rsv_ones_read: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(st_r == TCM_BUS_ACK && avs_read && hit_mode) |=>
			(avs_readdata[RSV_HI_POS:RSV_LO_POS] == 2'h3))
		else $error("reserved top bits of a mode register did not read as one");

	chk_buf_b_follow: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ch0_wr |-> ##2 (buf_b_en[0] == $past(avs_writedata[BUF_B_POS], 2)))
		else $error("buffer B enable did not follow the written bit");

	chk_d_evt_block: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(buf_b_en & evt_d_out) == 6'h00)
		else $error("register D event passed while it buffers register B");

	chk_no_d_buf: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ch1_wr |-> ##1 (slot_val[1][BUF_B_POS] == 1'b0) ##1 !buf_b_en[1])
		else $error("buffer B bit took a value on a channel without register D");

	chk_buf_a_follow: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ch0_wr |-> ##2 (buf_a_en[0] == $past(avs_writedata[BUF_A_POS], 2)))
		else $error("buffer A enable did not follow the written bit");

	chk_c_evt_pass: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(!slot_buf_a[3] && evt_c_raw[3]) |=> evt_c_out[3])
		else $error("register C event lost while not buffering");

	chk_c_evt_block: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(buf_a_en & evt_c_out) == 6'h00)
		else $error("register C event passed while it buffers register A");

	chk_no_c_buf: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(buf_a_en & ~CD_MASK) == 6'h00)
		else $error("buffer A enable set on a channel without register C");

	chk_pwm1_decode: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(ch1_wr && avs_writedata[3:0] == MD_PWM1) |-> ##2 (mode_pwm1[1] && !mode_normal[1]))
		else $error("PWM mode 1 code did not select PWM mode 1");

	chk_md3_undef: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(ch1_wr && avs_writedata[MD_HI_POS]) |-> ##2 (mode_undef[1] && !mode_phase[1]))
		else $error("code with the top mode bit set was taken as a mode");

	chk_no_phase_cd: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(mode_phase & CD_MASK) == 6'h00)
		else $error("phase counting reported on channel zero or three");

	chk_one_wait: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(req && avs_waitrequest && st_r == TCM_BUS_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not given exactly one cycle after the request");

	chk_d_evt_pass: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(!slot_buf_b[0] && evt_d_raw[0]) |=> evt_d_out[0])
		else $error("register D event lost while not buffering");

	chk_no_d_mask: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(buf_b_en & ~CD_MASK) == 6'h00)
		else $error("buffer B enable set on a channel without register D");

	chk_normal_decode: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(ch0_wr && avs_writedata[3:0] == MD_NORMAL) |-> ##2 (mode_normal[0] && !mode_undef[0]))
		else $error("normal code did not select normal operation");

	chk_pwm2_decode: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(ch0_wr && avs_writedata[3:0] == MD_PWM2) |-> ##2 (mode_pwm2[0] && !mode_pwm1[0]))
		else $error("PWM mode 2 code did not select PWM mode 2");

	// Phase selection must follow the low code bits once the phase code lands.
	chk_phase_decode: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(ch1_wr && avs_writedata[3:2] == 2'h1) |->
			##2 (mode_phase[1] && phase_sel[3:2] == $past(avs_writedata[1:0], 2)))
		else $error("phase counting code did not select phase counting");
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	import tcm_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] adr = '0;
	logic rd_s = 1'b0;
	logic wr_s = 1'b0;
	logic [DATA_W-1:0] wdat = '0;
	logic [3:0] be = 4'h0;
	logic [DATA_W-1:0] rdat;
	logic [1:0] resp;
	logic wait_s;
	logic [CH_NUM-1:0] c_raw = '0;
	logic [CH_NUM-1:0] d_raw = '0;
	logic [CH_NUM-1:0] c_out, d_out, ba, bb, mn, m1, m2, mp, mu;
	logic [2*CH_NUM-1:0] psel;
	logic [CH_NUM-1:0] exp_c = '0;
	logic [CH_NUM-1:0] exp_d = '0;
	logic [7:0] mreg [CH_NUM];
	logic [31:0] seed = 32'h523D;
	logic [31:0] ev_seed = 32'h523D;
	logic [31:0] r, st;
	logic [1:0] rs;
	logic [8:0] dd;
	logic ev_on = 1'b0;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;

	tcm_mode_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(adr),
		.avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
		.avs_readdata(rdat), .avs_response(resp), .avs_waitrequest(wait_s),
		.evt_c_raw(c_raw), .evt_d_raw(d_raw), .evt_c_out(c_out), .evt_d_out(d_out),
		.buf_a_en(ba), .buf_b_en(bb), .mode_normal(mn), .mode_pwm1(m1),
		.mode_pwm2(m2), .mode_phase(mp), .phase_sel(psel), .mode_undef(mu));

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Channels 0 and 3 are the only ones with the C/D registers.
	function automatic logic [7:0] stored(input int ch, input logic [7:0] d);
		stored = (ch % 3 == 0) ? {2'h3, d[5:0]} : {4'hC, d[3:0]};
	endfunction

	function automatic logic [8:0] dec(input int ch, input logic [7:0] v);
		logic cd;
		cd = (ch % 3 == 0);
		dec = {v[3:0] == 4'h0, v[3:0] == 4'h2, v[3:0] == 4'h3, !cd && v[3:2] == 2'h1,
			v[3] || v[3:0] == 4'h1 || (cd && v[2]), v[4], v[5], v[1:0]};
	endfunction

	task automatic complete_run();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] e);
		int n;
		n = 0;
		@(posedge ref_clk);
		adr <= a;
		wdat <= d;
		be <= e;
		wr_s <= w;
		rd_s <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wait_s !== 1'b0 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("CHECK FAILED %0t no bus answer", $time);
		end
		r = rdat;
		rs = resp;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask

	task automatic wr_ch(input int ch, input logic [7:0] d, input logic [3:0] e);
		// The bench runs no channel counter, so every mode write meets the stopped rule.
		bus(1'b1, ADDR_W'(ch * 4), {24'h0, d}, e);
		if (e[0]) begin
			mreg[ch] = stored(ch, d);
		end
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK({mn[ch], m1[ch], m2[ch], mp[ch], mu[ch], ba[ch], bb[ch], psel[2*ch +: 2]}, dec(ch, mreg[ch]))
		bus(1'b0, ADDR_W'(ch * 4), 32'h0, 4'hF);
		`CHK(r, {24'h0, mreg[ch]})
		`CHK(rs, RESP_OK)
	endtask

	// Gating is checked on every edge, so any buffer enable change is exercised live.
	always @(posedge ref_clk) begin
		// Gated events and buffer enables leave one register stage together, so the
		// raw pulse of the last edge is gated by the enable that stands now.
		if (ev_on) begin
			`CHK(c_out, exp_c & ~ba)
			`CHK(d_out, exp_d & ~bb)
		end
		exp_c <= c_raw;
		exp_d <= d_raw;
		ev_seed = lfsr(ev_seed);
		c_raw <= ev_seed[5:0];
		d_raw <= ev_seed[13:8];
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			complete_run();
		end
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int ch = 0; ch < CH_NUM; ch++) begin
			mreg[ch] = MODE_RESET_VAL;
		end
		repeat (2) @(posedge ref_clk);
		#1 ev_on = 1'b1;
		`CHK(mn, 6'h3F)
		for (int ch = 0; ch < CH_NUM; ch++) begin
			bus(1'b0, ADDR_W'(ch * 4), 32'h0, 4'hF);
			`CHK(r, 32'h0000_00C0)
		end
		// Every code on a C/D channel and a plain one, buffer bits set too.
		for (int code = 0; code < 16; code++) begin
			wr_ch(0, {4'hF, 4'(code)}, 4'h1);
			wr_ch(1, {4'hF, 4'(code)}, 4'h1);
		end
		repeat (40) begin
			seed = lfsr(seed);
			wr_ch(int'(seed[2:0]) % 6, seed[15:8], seed[19:16] | {3'h0, seed[20] | seed[21]});
		end
		bus(1'b1, 5'h04, 32'h12, 4'hF);
		bus(1'b0, 5'h04, 32'h0, 4'hF);
		mreg[1] = 8'hC2;
		`CHK(r, 32'h0000_00C2)
		st = '0;
		for (int ch = 0; ch < CH_NUM; ch++) begin
			dd = dec(ch, mreg[ch]);
			st[STAT_UNDEF_POS + ch] = dd[4];
			st[STAT_PHASE_POS + ch] = dd[5];
		end
		bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
		`CHK(r, st)
		bus(1'b1, 5'h1C, 32'hFF, 4'hF);
		`CHK(rs, RESP_SLVERR)
		bus(1'b0, 5'h05, 32'h0, 4'hF);
		`CHK(rs, RESP_SLVERR)
		`CHK(r, 32'h0)
		complete_run();
	end
endmodule
`default_nettype wire
